// *** oadc_top.v ***
// operand address decode, cycle accounting and accumulator fill
`timescale 1ns/10ps
`default_nettype none
`include "oadc_consts.vh"
module oadc_top (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        instr_valid,
  input  wire [4:0]  ea_code,
  input  wire [1:0]  op_size,
  input  wire [2:0]  op_location,
  input  wire        op_addr_odd,
  input  wire        uses_ea_memory,
  input  wire [7:0]  base_cycles,
  input  wire [3:0]  instr_reg_accesses,
  input  wire [1:0]  prog_location,
  input  wire [2:0]  fetch_units,
  input  wire [7:0]  wait_cycles,
  input  wire        intermittent_en,
  input  wire [1:0]  intermittent_wait_select,
  input  wire        read_modify_write_flag,
  input  wire        acc_load,
  input  wire [31:0] acc_data,
  input  wire [1:0]  acc_low_upper_byte_op,
  input  wire [1:0]  acc_high_op,
  input  wire        imm_extend,
  input  wire [7:0]  imm8,
  output reg  [7:0]  form_out,
  output reg  [2:0]  byte_register_sel_out,
  output reg  [2:0]  word_register_sel_out,
  output reg  [1:0]  long_register_sel_out,
  output reg  [2:0]  pointer_register_sel_out,
  output reg  [1:0]  ext_bytes_out,
  output reg         ptr_increment,
  output reg  [11:0] total_cycles,
  output reg  [7:0]  access_count,
  output reg         rmw_out,
  output reg         result_valid,
  output reg  [15:0] acc_low_half,
  output reg  [15:0] acc_high_half,
  output reg  [15:0] sign_extended_immediate
);
  wire [7:0] form_w;
  wire [2:0] bsel_w;
  wire [2:0] wsel_w;
  wire [1:0] lsel_w;
  wire [2:0] psel_w;
  wire [1:0] ext_w;
  wire [3:0] acyc_w;
  wire [3:0] aacc_w;
  reg  [3:0] op_cor;
  reg  [3:0] op_acc;
  reg  [3:0] pf_per;
  reg  [7:0] stall_per;
  reg  [11:0] cycles_next;
  reg  [7:0] acc_next;
  reg  [15:0] low_next;
  reg  [15:0] high_next;

  oadc_ea_decode u_dec (
    .ea_code              (ea_code),
    .op_size              (op_size),
    .form                 (form_w),
    .byte_register_sel    (bsel_w),
    .word_register_sel    (wsel_w),
    .long_register_sel    (lsel_w),
    .pointer_register_sel (psel_w),
    .ext_bytes            (ext_w),
    .addr_cycles          (acyc_w),
    .reg_accesses         (aacc_w)
  );

  // operand access correction and access count by location
  always @* begin
    op_cor = 4'h0;
    op_acc = (op_size == `OADC_SZ_LONG) ? 4'h2 : 4'h1;
    case (op_location)
      `OADC_LOC_IMEM: begin
        if (op_addr_odd && op_size == `OADC_SZ_WORD) begin
          op_cor = `OADC_COR_ODD_W;
          op_acc = 4'h2;
        end else if (op_addr_odd && op_size == `OADC_SZ_LONG) begin
          op_cor = `OADC_COR_ODD_L;
          op_acc = 4'h4;
        end
      end
      `OADC_LOC_EXT16, `OADC_LOC_EXT8: begin
        if (op_size == `OADC_SZ_BYTE) begin
          op_cor = `OADC_COR_EXT_B;
        end else if (op_location == `OADC_LOC_EXT16 && !op_addr_odd) begin
          op_cor = (op_size == `OADC_SZ_WORD) ? `OADC_COR_EV_W : `OADC_COR_EV_L;
        end else begin
          // 8-bit bus or misaligned: each half split into byte cycles
          op_cor = (op_size == `OADC_SZ_WORD) ? `OADC_COR_SL_W : `OADC_COR_SL_L;
          op_acc = (op_size == `OADC_SZ_WORD) ? 4'h2 : 4'h4;
        end
      end
      default: begin
        op_cor = 4'h0;
      end
    endcase
  end

  // worst-case fetch cost: word units for 16-bit paths, bytes for 8-bit
  always @* begin
    case (prog_location)
      `OADC_PM_INT:   pf_per = `OADC_PF_INT;
      `OADC_PM_EXT16: pf_per = `OADC_PF_EXT;
      `OADC_PM_EXT8:  pf_per = `OADC_PF_EXT;
      default:        pf_per = 4'h0;
    endcase
  end

  // suspended cycles per access; select value taken as the count
  always @* begin
    stall_per = intermittent_en ? {6'h00, intermittent_wait_select} : 8'h00;
  end

  always @* begin
    acc_next = {4'h0, instr_reg_accesses} + {4'h0, op_acc};
    if (uses_ea_memory) begin
      acc_next = acc_next + {4'h0, aacc_w};
    end
    cycles_next = {4'h0, base_cycles}
                + {8'h00, op_cor}
                + {4'h0, wait_cycles}
                + {8'h00, pf_per} * {9'h000, fetch_units}
                + {4'h0, stall_per} * {4'h0, acc_next};
    if (uses_ea_memory) begin
      cycles_next = cycles_next + {8'h00, acyc_w};
    end
  end

  // accumulator fill
  always @* begin
    low_next  = acc_low_half;
    high_next = acc_high_half;
    if (acc_load) begin
      case (op_size)
        `OADC_SZ_BYTE: begin
          low_next[7:0] = acc_data[7:0];
          case (acc_low_upper_byte_op)
            `OADC_LH_ZERO: low_next[15:8] = 8'h00;
            `OADC_LH_SIGN: low_next[15:8] = {8{acc_data[7]}};
            default:       low_next[15:8] = acc_low_half[15:8];
          endcase
        end
        `OADC_SZ_WORD: low_next = acc_data[15:0];
        default: begin
          low_next  = acc_data[15:0];
          high_next = acc_data[31:16];
        end
      endcase
      if (op_size != `OADC_SZ_LONG) begin
        case (acc_high_op)
          `OADC_AH_COPY: high_next = acc_low_half;
          `OADC_AH_ZERO: high_next = 16'h0000;
          `OADC_AH_SIGN: high_next = {16{low_next[15]}};
          default:       high_next = acc_high_half;
        endcase
      end
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      form_out                 <= 8'h00;
      byte_register_sel_out    <= 3'h0;
      word_register_sel_out    <= 3'h0;
      long_register_sel_out    <= 2'h0;
      pointer_register_sel_out <= 3'h0;
      ext_bytes_out            <= 2'h0;
      ptr_increment            <= 1'b0;
      total_cycles             <= 12'h000;
      access_count             <= 8'h00;
      rmw_out                  <= 1'b0;
      result_valid             <= 1'b0;
      acc_low_half             <= 16'h0000;
      acc_high_half            <= 16'h0000;
      sign_extended_immediate  <= 16'h0000;
    end else begin
      result_valid  <= instr_valid;
      acc_low_half  <= low_next;
      acc_high_half <= high_next;
      if (instr_valid) begin
        form_out                 <= form_w;
        byte_register_sel_out    <= bsel_w;
        word_register_sel_out    <= wsel_w;
        long_register_sel_out    <= lsel_w;
        pointer_register_sel_out <= psel_w;
        ext_bytes_out            <= ext_w;
        ptr_increment            <= (form_w == `OADC_FORM_PINC);
        total_cycles             <= cycles_next;
        access_count             <= acc_next;
        // flag passed on only; the split-meaning check is software's job
        rmw_out                  <= read_modify_write_flag;
        sign_extended_immediate  <= imm_extend ? {{8{imm8[7]}}, imm8}
                                               : {8'h00, imm8};
      end
    end
  end
endmodule // oadc_top
`default_nettype wire

// *** oadc_consts.vh ***
// constants for the operand address decode and cycle count block
`ifndef OADC_CONSTS_VH
`define OADC_CONSTS_VH
// operand sizes
`define OADC_SZ_BYTE 2'h0
`define OADC_SZ_WORD 2'h1
`define OADC_SZ_LONG 2'h2
// operand location
`define OADC_LOC_REG   3'h0
`define OADC_LOC_IMEM  3'h1
`define OADC_LOC_EXT16 3'h2
`define OADC_LOC_EXT8  3'h3
// program memory location
`define OADC_PM_INT    2'h0
`define OADC_PM_EXT16  2'h1
`define OADC_PM_EXT8   2'h2
// addressing form codes (one-hot)
`define OADC_FORM_REG  8'h01
`define OADC_FORM_IND  8'h02
`define OADC_FORM_PINC 8'h04
`define OADC_FORM_D8   8'h08
`define OADC_FORM_D16  8'h10
`define OADC_FORM_IDX  8'h20
`define OADC_FORM_PCR  8'h40
`define OADC_FORM_DIR  8'h80
// addressing overhead cycles and register accesses
`define OADC_CYC_IND   4'h2
`define OADC_CYC_PINC  4'h4
`define OADC_CYC_PCR   4'h2
`define OADC_CYC_DIR   4'h1
`define OADC_ACC_IND   4'h1
`define OADC_ACC_PINC  4'h2
// operand access corrections
`define OADC_COR_ODD_W 4'h2
`define OADC_COR_ODD_L 4'h4
`define OADC_COR_EXT_B 4'h1
`define OADC_COR_EV_W  4'h1
`define OADC_COR_EV_L  4'h2
`define OADC_COR_SL_W  4'h4
`define OADC_COR_SL_L  4'h8
// program fetch corrections per boundary
`define OADC_PF_INT    4'h2
`define OADC_PF_EXT    4'h3
// accumulator fill codes
`define OADC_LH_KEEP   2'h0
`define OADC_LH_ZERO   2'h1
`define OADC_LH_SIGN   2'h2
`define OADC_AH_KEEP   2'h0
`define OADC_AH_COPY   2'h1
`define OADC_AH_ZERO   2'h2
`define OADC_AH_SIGN   2'h3
`endif

// *** oadc_ea_decode.v ***
// effective-address field decoder
`timescale 1ns/10ps
`default_nettype none
`include "oadc_consts.vh"
module oadc_ea_decode (
  input  wire [4:0] ea_code,
  input  wire [1:0] op_size,
  output reg  [7:0] form,
  output reg  [2:0] byte_register_sel,
  output reg  [2:0] word_register_sel,
  output reg  [1:0] long_register_sel,
  output reg  [2:0] pointer_register_sel,
  output reg  [1:0] ext_bytes,
  output reg  [3:0] addr_cycles,
  output reg  [3:0] reg_accesses
);
  always @* begin
    form                 = `OADC_FORM_REG;
    byte_register_sel    = 3'h0;
    word_register_sel    = 3'h0;
    long_register_sel    = 2'h0;
    pointer_register_sel = 3'h0;
    ext_bytes            = 2'h0;
    addr_cycles          = 4'h0;
    reg_accesses         = 4'h0;
    if (ea_code[4:3] == 2'h0) begin
      // register direct: long forms pair registers, so code/2 picks one
      form = `OADC_FORM_REG;
      if (op_size == `OADC_SZ_BYTE) begin
        byte_register_sel = ea_code[2:0];
      end else if (op_size == `OADC_SZ_WORD) begin
        word_register_sel = ea_code[2:0];
      end else begin
        long_register_sel = ea_code[2:1];
      end
    end else if (ea_code[4:2] == 3'h2) begin
      form = `OADC_FORM_IND;
      pointer_register_sel = {1'b0, ea_code[1:0]};
      addr_cycles = `OADC_CYC_IND;
      reg_accesses = `OADC_ACC_IND;
    end else if (ea_code[4:2] == 3'h3) begin
      form = `OADC_FORM_PINC;
      pointer_register_sel = {1'b0, ea_code[1:0]};
      addr_cycles = `OADC_CYC_PINC;
      reg_accesses = `OADC_ACC_PINC;
    end else if (ea_code[4:3] == 2'h2) begin
      form = `OADC_FORM_D8;
      pointer_register_sel = ea_code[2:0];
      ext_bytes = 2'h1;
      addr_cycles = `OADC_CYC_IND;
      reg_accesses = `OADC_ACC_IND;
    end else if (ea_code[4:2] == 3'h6) begin
      form = `OADC_FORM_D16;
      pointer_register_sel = {1'b0, ea_code[1:0]};
      ext_bytes = 2'h2;
      addr_cycles = `OADC_CYC_IND;
      reg_accesses = `OADC_ACC_IND;
    end else if (ea_code[1] == 1'b0) begin
      form = `OADC_FORM_IDX;
      pointer_register_sel = {2'h0, ea_code[0]};
      word_register_sel = 3'h7;
      addr_cycles = `OADC_CYC_PINC;
      reg_accesses = `OADC_ACC_PINC;
    end else if (ea_code[0] == 1'b0) begin
      form = `OADC_FORM_PCR;
      ext_bytes = 2'h2;
      addr_cycles = `OADC_CYC_PCR;
    end else begin
      form = `OADC_FORM_DIR;
      ext_bytes = 2'h2;
      addr_cycles = `OADC_CYC_DIR;
    end
  end
endmodule // oadc_ea_decode
`default_nettype wire

// *** oadc_checker.sv ***
// port-level assertions for the operand decode and cycle count block
`timescale 1ns/10ps
`default_nettype none
module oadc_checker (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        instr_valid,
  input wire logic [4:0]  ea_code,
  input wire logic [1:0]  op_size,
  input wire logic        acc_load,
  input wire logic [31:0] acc_data,
  input wire logic        imm_extend,
  input wire logic [7:0]  imm8,
  input wire logic [7:0]  form_out,
  input wire logic [1:0]  ext_bytes_out,
  input wire logic        ptr_increment,
  input wire logic [2:0]  pointer_register_sel_out,
  input wire logic [2:0]  word_register_sel_out,
  input wire logic [11:0] total_cycles,
  input wire logic [7:0]  access_count,
  input wire logic        result_valid,
  input wire logic [15:0] acc_high_half,
  input wire logic [15:0] sign_extended_immediate
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_valid_next: assert property (instr_valid |=> result_valid)
    else $error("no result flag after request");
  a_valid_pulse: assert property (!instr_valid |=> !result_valid)
    else $error("result flag without request");
  a_count_hold: assert property (!instr_valid |=>
    $stable(total_cycles) && $stable(access_count))
    else $error("counts moved without request");
  a_reg_direct: assert property (instr_valid && ea_code < 5'h08 |=>
    form_out == 8'h01 && ext_bytes_out == 2'h0)
    else $error("register form wrong");
  a_post_incr: assert property (instr_valid && ea_code[4:2] == 3'h3 |=>
    ptr_increment && pointer_register_sel_out == {1'b0, $past(ea_code[1:0])})
    else $error("post increment wrong");
  a_short_displacement_ext: assert property (instr_valid && ea_code[4:3] == 2'h2 |=>
    ext_bytes_out == 2'h1 && pointer_register_sel_out == $past(ea_code[2:0]))
    else $error("short displacement wrong");
  a_long_displacement_ext: assert property (instr_valid && ea_code[4:2] == 3'h6 |=>
    form_out == 8'h10 && ext_bytes_out == 2'h2)
    else $error("long displacement wrong");
  a_index_seven: assert property (instr_valid && ea_code[4:1] == 4'hE |=>
    form_out == 8'h20 && word_register_sel_out == 3'h7)
    else $error("index form wrong");
  a_pc_direct: assert property (instr_valid && ea_code[4:1] == 4'hF |=>
    ext_bytes_out == 2'h2 && !ptr_increment)
    else $error("pc relative or direct form wrong");
  a_imm_sign: assert property (instr_valid && imm_extend |=>
    sign_extended_immediate == {{8{$past(imm8[7])}}, $past(imm8)})
    else $error("immediate not sign extended");
  a_long_high: assert property (acc_load && op_size == 2'h2 |=>
    acc_high_half == $past(acc_data[31:16]))
    else $error("long load high half wrong");
endmodule // oadc_checker
bind oadc_top oadc_checker i_chk (
  .ref_clk                  (ref_clk),
  .rst                      (rst),
  .instr_valid              (instr_valid),
  .ea_code                  (ea_code),
  .op_size                  (op_size),
  .acc_load                 (acc_load),
  .acc_data                 (acc_data),
  .imm_extend               (imm_extend),
  .imm8                     (imm8),
  .form_out                 (form_out),
  .ext_bytes_out            (ext_bytes_out),
  .ptr_increment            (ptr_increment),
  .pointer_register_sel_out (pointer_register_sel_out),
  .word_register_sel_out    (word_register_sel_out),
  .total_cycles             (total_cycles),
  .access_count             (access_count),
  .result_valid             (result_valid),
  .acc_high_half            (acc_high_half),
  .sign_extended_immediate  (sign_extended_immediate)
);
`default_nettype wire

// *** oadc_bus_model.sv ***
// far-side bus model supplying ready wait cycles
`timescale 1ns/10ps
`default_nettype none
module oadc_bus_model (
  input  wire logic [2:0] op_location,
  input  wire logic [1:0] op_size,
  input  wire logic       op_addr_odd,
  input  wire logic       slow,
  output logic      [7:0] wait_cycles
);
  // internal places never wait; a slow external device waits longer for wider units
  always_comb begin
    wait_cycles = 8'h00;
    if ((op_location == 3'h2 || op_location == 3'h3) && slow)
      wait_cycles = {5'h00, op_size, op_addr_odd} + 8'h01;
  end
endmodule // oadc_bus_model
`default_nettype wire

// *** test_operand_address_decode_cycle_count.sv ***
// self-checking bench for the operand decode and cycle count block
`timescale 1ns/10ps
`default_nettype none
module test_operand_address_decode_cycle_count;
  logic        ref_clk, rst, instr_valid, op_addr_odd, uses_ea_memory, intermittent_en, slow;
  logic        read_modify_write_flag, acc_load, imm_extend, ptr_increment, rmw_out, result_valid;
  logic [1:0]  op_size, prog_location, intermittent_wait_select, acc_low_upper_byte_op;
  logic [1:0]  acc_high_op, long_register_sel_out, ext_bytes_out;
  logic [2:0]  op_location, fetch_units, byte_register_sel_out, word_register_sel_out;
  logic [2:0]  pointer_register_sel_out, ps;
  logic [3:0]  instr_reg_accesses;
  logic [4:0]  ea_code;
  logic [7:0]  base_cycles, wait_cycles, imm8, form_out, access_count, rs, rg;
  logic [11:0] total_cycles;
  logic [15:0] acc_low_half, acc_high_half, sign_extended_immediate, lo, hi, nl;
  logic [31:0] acc_data;
  integer      seed = 94364, fails = 0, num_checks = 0, i, f, ex, cy, ad, oa, oc, ac, tc;
  oadc_top i_dut (.*);
  oadc_bus_model i_bus (.*);
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task run(input logic [4:0] ea, input logic [1:0] sz, input logic [2:0] loc);
    @(posedge ref_clk);
    ea_code <= ea;
    op_size <= sz;
    op_location <= loc;
    uses_ea_memory <= ea > 5'h07;
    {op_addr_odd, slow, intermittent_en, read_modify_write_flag, acc_load, intermittent_wait_select,
     acc_high_op, fetch_units, instr_reg_accesses, base_cycles, imm8} <= $random(seed);
    acc_data <= $random(seed);
    imm_extend <= 1'($random(seed));
    acc_low_upper_byte_op <= 2'({$random(seed)} % 3);
    prog_location <= 2'({$random(seed)} % 3);
    instr_valid <= 1'b1;
    #1;
    f = ea < 8 ? 1 : ea < 12 ? 2 : ea < 16 ? 4 : ea < 24 ? 8 : ea < 28 ? 16
        : ea < 30 ? 32 : ea == 30 ? 64 : 128;
    // only the register set matching the operand size is selected
    rs = {sz == 0 ? ea[2:0] : 3'h0, sz == 1 ? ea[2:0] : 3'h0, sz == 2 ? ea[2:1] : 2'h0};
    ps = f == 8 ? ea[2:0] : f == 32 ? {2'h0, ea[0]} : {1'b0, ea[1:0]};
    ex = f == 8 ? 1 : (f >= 16 && f != 32) ? 2 : 0;
    cy = (f == 4 || f == 32) ? 4 : f == 128 ? 1 : f > 1 ? 2 : 0;
    ad = (f == 4 || f == 32) ? 2 : (f > 1 && f < 64) ? 1 : 0;
    oa = sz == 2 ? 2 : 1;
    oc = 0;
    if (loc == 2 && !op_addr_odd) oc = oa;
    if ((loc == 2 && op_addr_odd) || loc == 3) oc = sz ? 4 * sz : 1;
    if (loc == 1 && op_addr_odd) oc = 2 * sz;
    if (((loc == 1 || loc == 2) && op_addr_odd) || loc == 3) oa = sz ? 2 * sz : 1;
    ac = instr_reg_accesses + oa + (ea > 7 ? ad : 0);
    tc = base_cycles + oc + wait_cycles + (prog_location ? 3 : 2) * fetch_units
         + (intermittent_en ? intermittent_wait_select * ac : 0) + (ea > 7 ? cy : 0);
    if (acc_load) begin
      nl = sz ? acc_data[15:0] : {lo[15:8], acc_data[7:0]};
      if (!sz && acc_low_upper_byte_op) nl[15:8] = acc_low_upper_byte_op == 1 ? 8'h00 : {8{acc_data[7]}};
      hi = sz == 2 ? acc_data[31:16] : acc_high_op == 1 ? lo : acc_high_op == 2 ? 16'h0000
           : acc_high_op == 3 ? {16{nl[15]}} : hi;
      lo = nl;
    end
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    acc_load <= 1'b0;
    #1;
    rg = {byte_register_sel_out, word_register_sel_out, long_register_sel_out};
    check(result_valid, 1);
    check(form_out, f);
    check(ext_bytes_out, ex);
    check(ptr_increment, f == 4);
    check(access_count, ac);
    check(total_cycles, tc);
    check(rmw_out, read_modify_write_flag);
    check(sign_extended_immediate, imm_extend ? {{8{imm8[7]}}, imm8} : {8'h00, imm8});
    check({acc_high_half, acc_low_half}, {hi, lo});
    if (f == 1) check(rg, rs);
    if (f > 1 && f < 64) check(pointer_register_sel_out, ps);
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    rst = 1'b1;
    {instr_valid, ea_code, op_size, op_location, op_addr_odd, uses_ea_memory, base_cycles, slow} = 0;
    {instr_reg_accesses, prog_location, fetch_units, intermittent_en, intermittent_wait_select} = 0;
    {read_modify_write_flag, acc_load, acc_data, acc_low_upper_byte_op, acc_high_op} = 0;
    imm_extend = 1'b1;
    imm8 = 8'h00;
    lo = 16'h0000;
    hi = 16'h0000;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    for (i = 0; i < 160; i = i + 1) run(i[4:0], 2'(i % 3), 3'(i % 5));
    $display("test every code done");
    for (i = 0; i < 600; i = i + 1) run(5'($random(seed)), 2'({$random(seed)} % 3), 3'({$random(seed)} % 5));
    $display("test random mix done");
    @(posedge ref_clk);
    rst <= 1'b1;
    @(posedge ref_clk);
    #1;
    check({total_cycles, access_count, result_valid}, 0);
    check({acc_high_half, acc_low_half}, 0);
    check({form_out, sign_extended_immediate}, 0);
    @(posedge ref_clk);
    rst <= 1'b0;
    lo = 16'h0000;
    hi = 16'h0000;
    run(5'h1F, 2'h2, 3'h3);
    $display("test mid-run reset done");
    end_of_test;
  end
endmodule // test_operand_address_decode_cycle_count
`default_nettype wire
